// ===== src/qeqc_pkg.sv
// package of constants and types for the quad equalizer control block
package qeqc_pkg;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned BOOST_W = 3;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_BOOST = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_EFFECT = 4'h2;
  localparam logic [3:0] OFF_CHAN_BOOST0 = 4'h4;
  // field positions
  localparam int unsigned STAT_SD_LSB = 0;
  localparam int unsigned STAT_EN_LSB = 4;
  // reset values
  localparam logic [2:0] BOOST_RESET = 3'h4;
  localparam logic [7:0] READ_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // pull levels of undriven pins
  localparam logic PULL_ENABLE = 1'b1;
  localparam logic PULL_FORCE = 1'b1;
  localparam logic [2:0] PULL_BOOST = 3'h4;
  localparam logic PULL_DATA = 1'b1;
  localparam logic PULL_CLOCK = 1'b1;
  typedef logic [2:0] qeqc_boost_t;
endpackage

// ===== src/qeqc_chan_if.sv
// interface carrying one channel's control and status
`timescale 1ns/100ps
`default_nettype none
interface qeqc_chan_if;
  logic enable;
  logic detect_raw;
  qeqc_pkg::qeqc_boost_t boost;
  logic active;
  logic detect;
  qeqc_pkg::qeqc_boost_t boost_out;
  modport ctrl (output enable, output detect_raw, output boost, input active, input detect,
    input boost_out);
  modport chan (input enable, input detect_raw, input boost, output active, output detect,
    output boost_out);
endinterface
`default_nettype wire

// ===== src/qeqc_chan.sv
// one equalizer channel: enable, detect and boost registers
`timescale 1ns/100ps
`default_nettype none
module qeqc_chan (
  input wire logic clk,
  input wire logic nrst,
  qeqc_chan_if.chan c
);
  logic active;
  logic detect;
  qeqc_pkg::qeqc_boost_t boost_out;
  logic next_active;
  logic next_detect;
  qeqc_pkg::qeqc_boost_t next_boost_out;
  always_comb begin
    next_active = c.enable;
    next_detect = c.detect_raw & c.enable;
    next_boost_out = c.boost;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active <= 1'b0;
      detect <= 1'b0;
      boost_out <= qeqc_pkg::BOOST_RESET;
    end else begin
      active <= next_active;
      detect <= next_detect;
      boost_out <= next_boost_out;
    end
  end
  assign c.active = active;
  assign c.detect = detect;
  assign c.boost_out = boost_out;
  AST_CHAN_ACTIVE: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> active == $past(c.enable)) else $error("channel active not following enable");
  AST_CHAN_DETECT: assert property (@(posedge clk) disable iff (!nrst)
    detect |-> $past(c.detect_raw)) else $error("detect without signal");
endmodule // qeqc_chan
`default_nettype wire

// ===== src/qeqc_top.sv
// top of the quad equalizer control block
// Behaviour
// - channel runs when enabled, standby when low
// - undriven enable reads as high
// - force high takes boost from pins
// - force low takes boost from registers
// - undriven force reads as high
// - detect output high when signal present and channel enabled
// - register access only with select high
// - select low makes bus accesses ignored
// - data pin bidirectional, pulled high
// - pin boost shared by all channels
// - boost pin pulls high, low, low
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module qeqc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] chan_enable_in,
  input wire logic [3:0] chan_enable_oe,
  input wire logic force_pin_boost_in,
  input wire logic force_pin_boost_oe,
  input wire logic [2:0] boost_select_in,
  input wire logic [2:0] boost_select_oe,
  input wire logic [3:0] signal_present,
  input wire logic mgmt_bus_clock_pin_in,
  input wire logic mgmt_bus_clock_pin_oe,
  input wire logic mgmt_data_in,
  input wire logic mgmt_data_ext_oe,
  input wire logic reg_select,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output var logic [7:0] reg_rdata,
  output var logic [3:0] chan_active,
  output var logic [3:0] chan_signal_detect,
  output var logic [11:0] chan_boost,
  output var logic mgmt_data_out,
  output var logic mgmt_data_oe,
  output var logic mgmt_clock_level,
  output var logic mgmt_data_level
);
  logic [3:0] en_eff;
  logic force_eff;
  qeqc_pkg::qeqc_boost_t pin_boost;
  qeqc_pkg::qeqc_boost_t reg_boost;
  qeqc_pkg::qeqc_boost_t next_reg_boost;
  qeqc_pkg::qeqc_boost_t sel_boost;
  logic [7:0] next_rdata;
  logic next_data_out;
  logic next_data_oe;
  logic next_clock_level;
  logic next_data_level;
  logic [3:0] act_w;
  logic [3:0] det_w;
  logic [11:0] bst_w;
  logic wr_ok;
  logic rd_ok;

  // pull resolution of undriven pins
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      en_eff[i] = chan_enable_oe[i] ? chan_enable_in[i] : qeqc_pkg::PULL_ENABLE;
    end
    force_eff = force_pin_boost_oe ? force_pin_boost_in : qeqc_pkg::PULL_FORCE;
    for (int b = 0; b < 3; b++) begin
      pin_boost[b] = boost_select_oe[b] ? boost_select_in[b] : qeqc_pkg::PULL_BOOST[b];
    end
    sel_boost = force_eff ? pin_boost : reg_boost;
  end

  always_comb begin
    wr_ok = reg_write & reg_select;
    rd_ok = reg_read & reg_select;
    next_reg_boost = reg_boost;
    if (wr_ok && reg_addr == qeqc_pkg::OFF_BOOST) begin
      next_reg_boost = reg_wdata[2:0];
    end
    next_rdata = qeqc_pkg::READ_RESET;
    if (rd_ok) begin
      if (reg_addr == qeqc_pkg::OFF_BOOST) begin
        next_rdata = {5'h00, reg_boost};
      end else if (reg_addr == qeqc_pkg::OFF_STATUS) begin
        next_rdata = {act_w, det_w};
      end else if (reg_addr == qeqc_pkg::OFF_EFFECT) begin
        next_rdata = {4'h0, force_eff, sel_boost};
      end else if (reg_addr[3:2] == qeqc_pkg::OFF_CHAN_BOOST0[3:2]) begin
        next_rdata = {5'h00, bst_w[reg_addr[1:0]*3 +: 3]};
      end else begin
        next_rdata = qeqc_pkg::UNMAPPED_DATA;
      end
    end
    next_data_oe = rd_ok;
    next_data_out = rd_ok ? ^next_rdata : qeqc_pkg::PULL_DATA;
    next_data_level = mgmt_data_oe ? mgmt_data_out :
      (mgmt_data_ext_oe ? mgmt_data_in : qeqc_pkg::PULL_DATA);
    next_clock_level = mgmt_bus_clock_pin_oe ? mgmt_bus_clock_pin_in :
      qeqc_pkg::PULL_CLOCK;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_boost <= qeqc_pkg::BOOST_RESET;
      reg_rdata <= qeqc_pkg::READ_RESET;
      mgmt_data_out <= qeqc_pkg::PULL_DATA;
      mgmt_data_oe <= 1'b0;
      mgmt_data_level <= qeqc_pkg::PULL_DATA;
      mgmt_clock_level <= qeqc_pkg::PULL_CLOCK;
      chan_active <= 4'h0;
      chan_signal_detect <= 4'h0;
      chan_boost <= {4{qeqc_pkg::BOOST_RESET}};
    end else begin
      reg_boost <= next_reg_boost;
      reg_rdata <= next_rdata;
      mgmt_data_out <= next_data_out;
      mgmt_data_oe <= next_data_oe;
      mgmt_data_level <= next_data_level;
      mgmt_clock_level <= next_clock_level;
      chan_active <= act_w;
      chan_signal_detect <= det_w;
      chan_boost <= bst_w;
    end
  end

  // one shared boost feeds every channel
  for (genvar g = 0; g < 4; g++) begin : g_chan
    qeqc_chan_if cif ();
    assign cif.enable = en_eff[g];
    assign cif.detect_raw = signal_present[g];
    assign cif.boost = sel_boost;
    assign act_w[g] = cif.active;
    assign det_w[g] = cif.detect;
    assign bst_w[g*3 +: 3] = cif.boost_out;
    qeqc_chan u_chan (
      .clk(clk),
      .nrst(nrst),
      .c(cif.chan)
    );
  end

  AST_WRITE_REFUSED: assert property (@(posedge clk) disable iff (!nrst)
    (reg_write && !reg_select) |=> (reg_boost == $past(reg_boost)))
    else $error("write accepted while deselected");
  AST_WRITE_TAKEN: assert property (@(posedge clk) disable iff (!nrst)
    (reg_write && reg_select && reg_addr == qeqc_pkg::OFF_BOOST) |=>
    (reg_boost == $past(reg_wdata[2:0]))) else $error("write not stored");
  AST_READ_REFUSED: assert property (@(posedge clk) disable iff (!nrst)
    (reg_read && !reg_select) |=> (reg_rdata == 8'h00 && !mgmt_data_oe))
    else $error("read answered while deselected");
  AST_PIN_BOOST: assert property (@(posedge clk) disable iff (!nrst)
    (force_eff && $stable(pin_boost)) |=> ##1 (chan_boost[2:0] == $past(pin_boost, 2)))
    else $error("pin boost not applied");
  AST_REG_BOOST: assert property (@(posedge clk) disable iff (!nrst)
    !force_eff |=> ##1 (chan_boost[11:9] == $past(reg_boost, 2)))
    else $error("register boost not applied");
  AST_SHARED_BOOST: assert property (@(posedge clk) disable iff (!nrst)
    chan_boost[2:0] == chan_boost[5:3] && chan_boost[5:3] == chan_boost[11:9])
    else $error("channels disagree on boost");
  // enable pin of channel 0 left undriven for two cycles
  sequence s_enable_released;
    (!chan_enable_oe[0]) ##1 (!chan_enable_oe[0]);
  endsequence
  AST_ENABLE_PULL: assert property (@(posedge clk) disable iff (!nrst)
    s_enable_released |=> chan_active[0])
    else $error("undriven enable not high");
  AST_READ_DRIVES: assert property (@(posedge clk) disable iff (!nrst)
    (reg_read && reg_select) |=> mgmt_data_oe)
    else $error("accepted read did not drive data line");
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    !(reg_read && reg_select) |=> (reg_rdata == 8'h00 && !mgmt_data_oe))
    else $error("read data standing without a read");
  AST_DETECT_OUT: assert property (@(posedge clk) disable iff (!nrst)
    (chan_signal_detect & ~$past(signal_present, 2)) == 4'h0)
    else $error("detect output high without signal");
  AST_DATA_PULL: assert property (@(posedge clk) disable iff (!nrst)
    (!mgmt_data_oe && !mgmt_data_ext_oe) |=> mgmt_data_level)
    else $error("undriven data line not high");
endmodule // qeqc_top
`default_nettype wire

// ===== sim/qeqc_host_model.sv
// board host model driving the control pins of the equalizer block
`timescale 1ns/100ps
`default_nettype none
module qeqc_host_model (
  input wire logic clk,
  output var logic [3:0] en_in,
  output var logic [3:0] en_oe,
  output var logic f_in,
  output var logic f_oe,
  output var logic [2:0] b_in,
  output var logic [2:0] b_oe,
  output var logic [3:0] sig,
  output var logic ck_in,
  output var logic ck_oe,
  output var logic d_in,
  output var logic d_oe
);
  // clock and data released: lines show the inverse of their pull level
  initial begin
    {en_in, en_oe, f_in, f_oe, b_oe, sig} = '0;
    b_in = 3'h3;
    ck_in = 1'b0;
    ck_oe = 1'b0;
    d_in = 1'b0;
    d_oe = 1'b0;
  end
  // undriven pins carry the inverse of the pull so the pull must win
  task automatic pins(input logic [3:0] e, eo, input logic f, fo, input logic [2:0] b, bo,
    input logic [3:0] s);
    @(posedge clk);
    en_in <= (e & eo) | (4'h0 & ~eo);
    en_oe <= eo;
    f_in <= fo ? f : 1'b0;
    f_oe <= fo;
    b_in <= (b & bo) | (3'h3 & ~bo);
    b_oe <= bo;
    sig <= s;
  endtask
endmodule // qeqc_host_model
`default_nettype wire

// ===== sim/test_qeqc_top.sv
// self-checking testbench of the quad equalizer control block
`timescale 1ns/100ps
`default_nettype none
module test_qeqc_top;
  logic clk, nrst, sel, wr_s, rd_s;
  logic [3:0] addr, en_in, en_oe, sig;
  logic [7:0] wdata, rdata;
  logic f_in, f_oe, ck_in, ck_oe, d_in, d_oe, d_out, d_doe, ck_lvl, d_lvl;
  logic [2:0] b_in, b_oe;
  logic [3:0] act, det;
  logic [11:0] boost;
  int n_fail = 0;
  int n_tests = 0;
  qeqc_host_model host_u (.clk(clk), .en_in(en_in), .en_oe(en_oe), .f_in(f_in), .f_oe(f_oe),
    .b_in(b_in), .b_oe(b_oe), .sig(sig), .ck_in(ck_in), .ck_oe(ck_oe), .d_in(d_in),
    .d_oe(d_oe));
  qeqc_top dut_u (.clk(clk), .nrst(nrst), .chan_enable_in(en_in), .chan_enable_oe(en_oe),
    .force_pin_boost_in(f_in), .force_pin_boost_oe(f_oe), .boost_select_in(b_in),
    .boost_select_oe(b_oe), .signal_present(sig), .mgmt_bus_clock_pin_in(ck_in),
    .mgmt_bus_clock_pin_oe(ck_oe), .mgmt_data_in(d_in), .mgmt_data_ext_oe(d_oe),
    .reg_select(sel), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s),
    .reg_rdata(rdata), .chan_active(act), .chan_signal_detect(det), .chan_boost(boost),
    .mgmt_data_out(d_out), .mgmt_data_oe(d_doe), .mgmt_clock_level(ck_lvl),
    .mgmt_data_level(d_lvl));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [11:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic oe);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk({4'h0, rdata}, {4'h0, exp});
    chk({11'h0, d_doe}, {11'h0, oe});
    chk({11'h0, d_out}, {11'h0, (oe ? ^exp : qeqc_pkg::PULL_DATA)});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(300 * 100);
    n_fail++;
    conclude();
  end
  initial begin
    {nrst, sel, wr_s, rd_s, addr, wdata} = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk({8'h0, act}, 12'h00f);
    chk(boost, 12'h924);
    chk({10'h0, ck_lvl, d_lvl}, 12'h003);
    host_u.pins(4'h5, 4'hf, 1'b1, 1'b1, 3'h3, 3'h7, 4'hf);
    settle();
    chk({8'h0, act}, 12'h005);
    chk({8'h0, det}, 12'h005);
    chk(boost, 12'h6db);
    sel <= 1'b1;
    wr(qeqc_pkg::OFF_BOOST, 8'h02);
    host_u.pins(4'h5, 4'hf, 1'b0, 1'b1, 3'h7, 3'h7, 4'h3);
    settle();
    chk(boost, 12'h492);
    rd(qeqc_pkg::OFF_STATUS, 8'h51, 1'b1);
    rd(4'h3, qeqc_pkg::UNMAPPED_DATA, 1'b1);
    rd(qeqc_pkg::OFF_BOOST, 8'h02, 1'b1);
    rd(qeqc_pkg::OFF_EFFECT, 8'h02, 1'b1);
    rd(4'h5, 8'h02, 1'b1);
    sel <= 1'b0;
    wr(qeqc_pkg::OFF_BOOST, 8'h07);
    settle();
    chk(boost, 12'h492);
    rd(qeqc_pkg::OFF_STATUS, 8'h00, 1'b0);
    settle();
    conclude();
  end
endmodule // test_qeqc_top
`default_nettype wire
